//--- crf_consts.svh
`ifndef CRF_CONSTS_SVH
`define CRF_CONSTS_SVH

// Register port byte offsets.
`define CRF_OFF_SP    8'h34
`define CRF_OFF_LR    8'h38
`define CRF_OFF_PC    8'h3c
`define CRF_OFF_PSW   8'h40
`define CRF_OFF_APP   8'h44
`define CRF_OFF_INT   8'h48
`define CRF_OFF_EXE   8'h4c
`define CRF_OFF_PRIM  8'h50
`define CRF_OFF_FLTM  8'h54
`define CRF_OFF_BPRI  8'h58
`define CRF_OFF_CTRL  8'h5c
`define CRF_OFF_MSP   8'h60
`define CRF_OFF_PSP   8'h64

// Field layouts of the status word and the aligned pointers.
`define CRF_APP_MASK  32'hf800_0000
`define CRF_APP_LSB   27
`define CRF_INT_MASK  32'h0000_01ff
`define CRF_EXE_MASK  32'h0600_fc00
`define CRF_EXE_CBIT  24
`define CRF_SP_MASK   32'hffff_fffc
`define CRF_PC_MASK   32'hffff_fffe

// Sizes and reset values.
`define CRF_NUM_GPR   13
`define CRF_NUM_LOW   4'h8
`define CRF_BPRI_W    9
`define CRF_RST_WORD  32'h0000_0000

`endif

//--- crf_pkg.sv
package crf_pkg;

    // Execution mode; handler runs only while an exception is serviced.
    typedef enum logic
    {
        crf_thread  = 1'b0,
        crf_handler = 1'b1
    } crf_mode_e;

    // Kind of an exception that asks to be taken.
    typedef enum logic [1:0]
    {
        crf_req_nmi   = 2'b00,
        crf_req_hard  = 2'b01,
        crf_req_other = 2'b10
    } crf_req_e;

    // Two-bit mode control word.
    typedef struct packed
    {
        logic stack_sel;
        logic user;
    } crf_ctrl_s;

    // Exception request with its priority value.
    typedef struct packed
    {
        crf_req_e   kind;
        logic [8:0] pri;
    } crf_req_s;

endpackage : crf_pkg

//--- crf_gpr_mem.sv
`timescale 1ns/100ps

// Storage for the general purpose bank; read data leave a register.
module crf_gpr_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 13,
    parameter int AW    = 4
)(
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             rstn,
    // Write side.
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    // Read side.
    input  wire logic             rd_en,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata_q
);

    // The array itself has no reset, as a register bank would not.
    logic [WIDTH-1:0] mem [DEPTH];

    // Write port.
    always_ff @(posedge core_clk)
    begin
        if (wr_en)
            mem[waddr] <= wdata;
    end

    // Read data load on a read and clear to zero otherwise, so they stand one cycle after it.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            rdata_q <= '0;
        else if (rd_en)
            rdata_q <= mem[raddr];
        else
            rdata_q <= '0;
    end

endmodule : crf_gpr_mem

//--- crf_mask.sv
`timescale 1ns/100ps

// Decides whether an exception request may be taken under the masks.
module crf_mask #(
    parameter int BPRI_W = 9
)(
    // Mask state.
    input  wire logic              prim,
    input  wire logic              fltm,
    input  wire logic [BPRI_W-1:0] bpri,
    // Request and verdict.
    input  wire crf_pkg::crf_req_s req,
    output logic                   ok
);
    import crf_pkg::*;

    // Named terms of the decision.
    wire is_nmi   = (req.kind == crf_req_nmi);
    wire is_hard  = (req.kind == crf_req_hard);
    wire is_other = (req.kind == crf_req_other);
    // Zero threshold disables masking; equal or higher values are blocked.
    wire pri_pass = (bpri == '0) || (req.pri[BPRI_W-1:0] < bpri);

    // Fault mask leaves only the non-maskable one; priority mask also hard fault.
    assign ok = is_nmi
              || (is_hard && !fltm)
              || (is_other && !fltm && !prim && pri_pass);

endmodule : crf_mask

//--- crf_core_regs.sv
`timescale 1ns/100ps
`include "crf_consts.svh"

module crf_core_regs #(
    parameter int NUM_GPR = `CRF_NUM_GPR,
    parameter int BPRI_W  = `CRF_BPRI_W
)(
    // Clock and reset.
    input  wire logic              core_clk,
    input  wire logic              rstn,
    // Register port from the execution pipeline.
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic              reg_narrow,
    output logic      [31:0]       reg_rdata,
    // Pipeline events.
    input  wire logic              call_valid,
    input  wire logic [31:0]       call_ret_addr,
    input  wire logic              pc_load,
    input  wire logic [31:0]       pc_next,
    input  wire logic              flags_wr,
    input  wire logic [4:0]        flags_in,
    // Exception handling.
    input  wire logic              exc_entry,
    input  wire logic [8:0]        exc_num,
    input  wire logic              exc_return,
    input  wire crf_pkg::crf_req_s req,
    output logic                   req_ok,
    // State seen by the core.
    output logic      [31:0]       instruction_pointer,
    output logic      [31:0]       stack_ptr,
    output logic      [8:0]        exc_active_num,
    output logic                   handler_mode,
    output logic                   privileged,
    output logic                   fault
);
    import crf_pkg::*;

    // Merges the masked field of a new value into an old word.
    function automatic logic [31:0] mask_wr(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [31:0] m);
        mask_wr = (old_v & ~m) | (new_v & m);
    endfunction : mask_wr

    // Architectural state.
    crf_mode_e          mode_q;      // Thread or handler.
    crf_ctrl_s          ctrl_q;      // Mode control bits.
    logic [31:0]        msp_q;       // Main stack.
    logic [31:0]        psp_q;       // Process stack.
    logic [31:0]        lr_q;        // Return address holder.
    logic [31:0]        pc_q;        // Instruction pointer.
    logic [31:0]        app_q;       // Application status, flag bits only.
    logic [31:0]        int_q;       // Interrupt status, number only.
    logic [31:0]        exe_q;       // Execution status, stored fields only.
    logic               prim_q;      // Global priority mask.
    logic               fltm_q;      // Fault escalation mask.
    logic [BPRI_W-1:0]  bpri_q;      // Priority threshold.
    logic               fault_q;     // One-cycle fault pulse.
    logic               gpr_sel_q;   // Previous cycle held a bank read.
    logic [31:0]        spec_q;      // Registered read data of other registers.
    logic [31:0]        gpr_rdata;   // Bank read data.

    // Address decode.
    wire [7:0] a       = reg_addr;
    wire [3:0] gidx    = a[5:2];
    wire       aligned = (a[1:0] == 2'b00);
    wire       is_gpr  = aligned && (a < `CRF_OFF_SP);
    wire       hi_reg  = is_gpr && (gidx >= `CRF_NUM_LOW);

    // Mode derived terms; handler is never user level.
    wire in_handler = (mode_q == crf_handler);
    wire user_lvl   = !in_handler && ctrl_q.user;
    // Process stack only out of handler mode, when selected or at user level.
    wire use_psp    = !in_handler && (ctrl_q.stack_sel || ctrl_q.user);

    // Status word and registers from INT to PSP are closed to user level; narrow forms see low bank only.
    wire restricted = (a == `CRF_OFF_PSW) ||
                      (aligned && a >= `CRF_OFF_INT && a <= `CRF_OFF_PSP);
    wire deny_user  = user_lvl && restricted;
    wire deny_hi    = reg_narrow && hi_reg;
    wire deny       = deny_user || deny_hi;
    wire wr_ok      = reg_wr && !deny;
    wire rd_ok      = reg_rd && !deny;

    // Write selects.
    wire w_gpr  = wr_ok && is_gpr;
    wire w_sp   = wr_ok && (a == `CRF_OFF_SP);
    wire w_lr   = wr_ok && (a == `CRF_OFF_LR);
    wire w_pc   = wr_ok && (a == `CRF_OFF_PC);
    wire w_psw  = wr_ok && (a == `CRF_OFF_PSW);
    wire w_app  = wr_ok && (a == `CRF_OFF_APP);
    wire w_exe  = wr_ok && (a == `CRF_OFF_EXE);
    wire w_prim = wr_ok && (a == `CRF_OFF_PRIM);
    wire w_fltm = wr_ok && (a == `CRF_OFF_FLTM);
    wire w_bpri = wr_ok && (a == `CRF_OFF_BPRI);
    wire w_ctrl = wr_ok && (a == `CRF_OFF_CTRL);
    wire w_msp  = wr_ok && (a == `CRF_OFF_MSP);
    wire w_psp  = wr_ok && (a == `CRF_OFF_PSP);

    // A status write that tries to clear the compact state bit is a fault.
    wire exe_clear = (w_psw || w_exe) && !reg_wdata[`CRF_EXE_CBIT];

    // Aligned write data for the pointers.
    wire [31:0] sp_wdata = reg_wdata & `CRF_SP_MASK;
    wire [31:0] pc_wdata = reg_wdata & `CRF_PC_MASK;

    // Status parts as read; the compact state bit always reads as one.
    wire [31:0] exe_rd = exe_q | (32'h1 << `CRF_EXE_CBIT);
    wire [31:0] psw_rd = app_q | int_q | exe_rd;

    // Mode control as read; the stack bit reads zero in handler mode.
    wire [31:0] ctrl_rd = {30'h0, ctrl_q.stack_sel && !in_handler, ctrl_q.user};

    // Read mux for everything outside the bank; denied or unmapped reads give zero.
    logic [31:0] spec_d;
    always_comb
    begin
        spec_d = `CRF_RST_WORD;
        if (rd_ok && aligned)
        begin
            case (a)
                `CRF_OFF_SP:   spec_d = use_psp ? psp_q : msp_q;
                `CRF_OFF_LR:   spec_d = lr_q;
                `CRF_OFF_PC:   spec_d = pc_q;
                `CRF_OFF_PSW:  spec_d = psw_rd;
                `CRF_OFF_APP:  spec_d = app_q;
                `CRF_OFF_INT:  spec_d = int_q;
                `CRF_OFF_EXE:  spec_d = exe_rd;
                `CRF_OFF_PRIM: spec_d = {31'h0, prim_q};
                `CRF_OFF_FLTM: spec_d = {31'h0, fltm_q};
                `CRF_OFF_BPRI: spec_d = {{(32-BPRI_W){1'b0}}, bpri_q};
                `CRF_OFF_CTRL: spec_d = ctrl_rd;
                `CRF_OFF_MSP:  spec_d = msp_q;
                `CRF_OFF_PSP:  spec_d = psp_q;
                default:       spec_d = `CRF_RST_WORD;
            endcase
        end
    end

    // General purpose bank, thirteen words of 32 bits.
    crf_gpr_mem #(
        .WIDTH (32),
        .DEPTH (NUM_GPR),
        .AW    (4)
    ) u_gpr (
        .core_clk (core_clk),
        .rstn     (rstn),
        .wr_en    (w_gpr),
        .waddr    (gidx),
        .wdata    (reg_wdata),
        .rd_en    (rd_ok && is_gpr),
        .raddr    (gidx),
        .rdata_q  (gpr_rdata)
    );

    // Read data stand in the cycle after the read and read zero otherwise.
    assign reg_rdata = gpr_sel_q ? gpr_rdata : spec_q;

    // Read path registers and the fault pulse.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gpr_sel_q <= 1'b0;
            spec_q    <= `CRF_RST_WORD;
            fault_q   <= 1'b0;
        end
        else
        begin
            gpr_sel_q <= rd_ok && is_gpr;
            spec_q    <= spec_d;
            fault_q   <= ((reg_wr || reg_rd) && deny) || exe_clear;
        end
    end

    // Exception entry and return move the mode and the active number.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_q <= crf_thread;
            int_q  <= `CRF_RST_WORD;
        end
        else if (exc_entry)
        begin
            mode_q <= crf_handler;
            int_q  <= {23'h0, exc_num} & `CRF_INT_MASK;
        end
        else if (exc_return)
        begin
            mode_q <= crf_thread;
            int_q  <= `CRF_RST_WORD;
        end
    end

    // Stack pointers; the alias address writes whichever one is in use.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            msp_q <= `CRF_RST_WORD;
            psp_q <= `CRF_RST_WORD;
        end
        else
        begin
            if (w_msp || (w_sp && !use_psp))
                msp_q <= sp_wdata;
            if (w_psp || (w_sp && use_psp))
                psp_q <= sp_wdata;
        end
    end

    // Return address holder; a call beats a port write in the same cycle.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            lr_q <= `CRF_RST_WORD;
        else if (call_valid)
            lr_q <= call_ret_addr;
        else if (w_lr)
            lr_q <= reg_wdata;
    end

    // Instruction pointer; a pipeline load beats a port write.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            pc_q <= `CRF_RST_WORD;
        else if (pc_load)
            pc_q <= pc_next & `CRF_PC_MASK;
        else if (w_pc)
            pc_q <= pc_wdata;
    end

    // Application and execution status; flag updates beat a port write.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            app_q <= `CRF_RST_WORD;
            exe_q <= `CRF_RST_WORD;
        end
        else
        begin
            if (flags_wr)
                app_q <= {flags_in, 27'h0};
            else if (w_psw || w_app)
                app_q <= mask_wr(app_q, reg_wdata, `CRF_APP_MASK);
            if (w_psw || w_exe)
                exe_q <= mask_wr(exe_q, reg_wdata, `CRF_EXE_MASK);
        end
    end

    // Mask registers and mode control.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prim_q <= 1'b0;
            fltm_q <= 1'b0;
            bpri_q <= '0;
            ctrl_q <= '0;
        end
        else
        begin
            if (w_prim)
                prim_q <= reg_wdata[0];
            if (w_fltm)
                fltm_q <= reg_wdata[0];
            if (w_bpri)
                bpri_q <= reg_wdata[BPRI_W-1:0];
            if (w_ctrl)
            begin
                ctrl_q.user      <= reg_wdata[0];
                // No alternate stack in handler mode, so a one is dropped there.
                ctrl_q.stack_sel <= reg_wdata[1] && !in_handler;
            end
        end
    end

    // Masking decision for pending exceptions.
    crf_mask #(
        .BPRI_W (BPRI_W)
    ) u_mask (
        .prim (prim_q),
        .fltm (fltm_q),
        .bpri (bpri_q),
        .req  (req),
        .ok   (req_ok)
    );

    // Outputs.
    assign instruction_pointer = pc_q;
    assign stack_ptr           = use_psp ? psp_q : msp_q;
    assign exc_active_num      = int_q[8:0];
    assign handler_mode        = in_handler;
    assign privileged          = !user_lvl;
    assign fault               = fault_q;

    // Checks on the state above.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_call;
        call_valid ##0 !pc_load;
    endsequence
    sequence s_entry;
        exc_entry ##1 (handler_mode && exc_active_num == $past(exc_num));
    endsequence

    a_lr_on_call: assert property (s_call |=> lr_q == $past(call_ret_addr))
        else $error("return address not captured");
    a_entry_num: assert property (exc_entry
        |-> s_entry)
        else $error("exception entry wrong");
    a_sp_aligned: assert property (stack_ptr[1:0] == 2'b00)
        else $error("stack pointer misaligned");
    a_pc_aligned: assert property (instruction_pointer[0] == 1'b0)
        else $error("instruction pointer misaligned");
    a_cbit_fault: assert property (exe_clear |=> fault && reg_rdata[24] == 1'b0)
        else $error("clearing compact bit did not fault");
    a_cbit_read: assert property (rd_ok && a == `CRF_OFF_EXE |=> reg_rdata[24])
        else $error("compact bit read as zero");
    a_narrow_high: assert property ((reg_wr || reg_rd) && deny_hi |=> fault && reg_rdata == 32'h0)
        else $error("narrow high access not refused");
    a_handler_priv: assert property (handler_mode |-> privileged && !use_psp)
        else $error("handler not privileged");
    a_flags_update: assert property (flags_wr |=> app_q[31:27] == $past(flags_in))
        else $error("flags not stored");
    a_prim_block: assert property (prim_q && req.kind == crf_req_other |-> !req_ok)
        else $error("priority mask let request through");
    a_fltm_block: assert property (fltm_q && req.kind != crf_req_nmi |-> !req_ok)
        else $error("fault mask let request through");
    a_thresh_block: assert property (bpri_q != '0 && req.kind == crf_req_other
        && req.pri >= bpri_q |-> !req_ok)
        else $error("threshold let request through");
    a_user_deny: assert property (reg_wr && deny_user |=> fault && $stable(ctrl_q))
        else $error("user access not refused");

endmodule : crf_core_regs

//--- crf_pipe_model.sv
`timescale 1ns/100ps
`include "crf_consts.svh"

// Stand-in for the execution pipeline and the exception logic.
module crf_pipe_model (
    // Clock.
    input  wire logic         core_clk,
    // Register port.
    output logic      [7:0]   reg_addr,
    output logic      [31:0]  reg_wdata,
    output logic              reg_wr,
    output logic              reg_rd,
    output logic              reg_narrow,
    input  wire logic [31:0]  reg_rdata,
    input  wire logic         fault,
    input  wire logic         handler_mode,
    // Events and requests.
    output logic              call_valid,
    output logic      [31:0]  call_ret_addr,
    output logic              pc_load,
    output logic      [31:0]  pc_next,
    output logic              flags_wr,
    output logic      [4:0]   flags_in,
    output logic              exc_entry,
    output logic      [8:0]   exc_num,
    output logic              exc_return,
    output crf_pkg::crf_req_s req
);
    import crf_pkg::*;

    logic [4:0]  ev_q;  // One-hot event pulses.
    logic [31:0] val_q; // Value carried by every event field.
    crf_req_s    req_q; // Request under test.
    logic [31:0] rd_q;  // Word seen after the last strobe.
    logic        flt_q; // Fault seen after the last strobe.

    // Sharing one value keeps the model small; only the pulsed field counts.
    assign call_valid    = ev_q[0];
    assign pc_load       = ev_q[1];
    assign flags_wr      = ev_q[2];
    assign exc_entry     = ev_q[3];
    assign exc_return    = ev_q[4];
    assign call_ret_addr = val_q;
    assign pc_next       = val_q;
    assign flags_in      = val_q[4:0];
    assign exc_num       = val_q[8:0];
    assign req           = req_q;

    // Everything idles low from time zero.
    initial
    begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, reg_narrow} = '0;
        ev_q  = '0;
        val_q = '0;
        req_q = '0;
    end

    // One strobe; answer and fault are taken in the cycle after it.
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          input logic nar);
        @(posedge core_clk);
        reg_wr     <= wr;
        reg_rd     <= ~wr;
        reg_addr   <= a;
        reg_narrow <= nar;
        // Handler mode has no alternate stack, so bit one is never asked for.
        reg_wdata  <= (wr && a == `CRF_OFF_CTRL && handler_mode) ? d & 32'hffff_fffd : d;
        @(posedge core_clk);
        reg_wr     <= 1'b0;
        reg_rd     <= 1'b0;
        reg_narrow <= 1'b0;
        // Released lines carry the inverse so stale values cannot pass.
        reg_addr   <= ~a;
        reg_wdata  <= ~d;
        #1;
        rd_q  = reg_rdata;
        flt_q = fault;
    endtask : access

    // One event pulse: 0 call, 1 pointer load, 2 flags, 3 entry, 4 return.
    task automatic pulse(input int k, input logic [31:0] v);
        @(posedge core_clk);
        ev_q  <= 5'(32'h1 << k);
        val_q <= v;
        @(posedge core_clk);
        ev_q  <= 5'h00;
        val_q <= ~v;
        #1;
    endtask : pulse

    // Present a request; the verdict is combinational.
    task automatic ask(input crf_req_s r);
        @(posedge core_clk);
        req_q <= r;
        #1;
    endtask : ask

endmodule : crf_pipe_model

//--- testbench.sv
`timescale 1ns/100ps
`include "crf_consts.svh"

// Self-checking bench for the core register file.
module testbench;
    import crf_pkg::*;

    // Write, then read back expecting exp.
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} crf_row_s;
    // Mask settings, request and the verdict it should get.
    typedef struct packed {logic p; logic f; logic [8:0] b; crf_req_s r; logic ok;} crf_mrow_s;

    localparam crf_row_s ROWS [12] = '{
        '{8'h00, 32'hdead_beef, 32'hdead_beef},
        '{8'h1c, 32'h0000_0007, 32'h0000_0007},
        '{8'h30, 32'h1234_5678, 32'h1234_5678},
        '{`CRF_OFF_SP, 32'h0000_1003, 32'h0000_1000},
        '{`CRF_OFF_LR, 32'h8000_0001, 32'h8000_0001},
        '{`CRF_OFF_PC, 32'h0000_2001, 32'h0000_2000},
        '{`CRF_OFF_APP, 32'hffff_ffff, 32'hf800_0000},
        '{`CRF_OFF_EXE, 32'hffff_ffff, 32'h0700_fc00},
        '{`CRF_OFF_PRIM, 32'h0000_0003, 32'h0000_0001},
        '{`CRF_OFF_FLTM, 32'h0000_0003, 32'h0000_0001},
        '{`CRF_OFF_BPRI, 32'h0000_03ff, 32'h0000_01ff},
        '{8'h80, 32'hffff_ffff, 32'h0000_0000}};

    localparam crf_mrow_s MROWS [9] = '{
        '{1'b0, 1'b0, 9'h000, '{crf_req_other, 9'h005}, 1'b1},
        '{1'b1, 1'b0, 9'h000, '{crf_req_other, 9'h000}, 1'b0},
        '{1'b1, 1'b0, 9'h000, '{crf_req_hard, 9'h000}, 1'b1},
        '{1'b1, 1'b0, 9'h000, '{crf_req_nmi, 9'h000}, 1'b1},
        '{1'b0, 1'b1, 9'h000, '{crf_req_hard, 9'h000}, 1'b0},
        '{1'b0, 1'b1, 9'h000, '{crf_req_nmi, 9'h000}, 1'b1},
        '{1'b0, 1'b0, 9'h004, '{crf_req_other, 9'h004}, 1'b0},
        '{1'b0, 1'b0, 9'h004, '{crf_req_other, 9'h005}, 1'b0},
        '{1'b0, 1'b0, 9'h004, '{crf_req_other, 9'h003}, 1'b1}};

    logic        core_clk;    // Bench clock, 50 MHz.
    logic        rstn;        // Active-low reset.
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, call_ret_addr, pc_next, instruction_pointer, stack_ptr;
    logic        reg_wr, reg_rd, reg_narrow, call_valid, pc_load, flags_wr;
    logic        exc_entry, exc_return, req_ok, handler_mode, privileged, fault;
    logic [4:0]  flags_in;
    logic [8:0]  exc_num, exc_active_num;
    crf_req_s    req;
    int          errors;      // Mismatches seen.
    int          check_count; // Comparisons made.

    crf_core_regs u_crf_core_regs (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_narrow, .reg_rdata, .call_valid, .call_ret_addr, .pc_load, .pc_next,
        .flags_wr, .flags_in, .exc_entry, .exc_num, .exc_return, .req, .req_ok,
        .instruction_pointer, .stack_ptr, .exc_active_num, .handler_mode, .privileged,
        .fault);

    crf_pipe_model u_crf_pipe_model (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_narrow, .reg_rdata, .fault, .handler_mode, .call_valid, .call_ret_addr,
        .pc_load, .pc_next, .flags_wr, .flags_in, .exc_entry, .exc_num, .exc_return, .req);

    // Free-running clock.
    always #10 core_clk = ~core_clk;

    // Compare one word and count it.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Register port shorthands.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_crf_pipe_model.access(1'b1, a, d, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic nar);
        u_crf_pipe_model.access(1'b0, a, 32'h0, nar);
    endtask : rd

    // Print the counts and the verdict, then stop.
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // Watchdog: the tests need well under a thousand cycles.
    initial
    begin
        repeat (5000) @(posedge core_clk);
        errors++;
        complete_run();
    end

    // Main sequence.
    initial
    begin
        core_clk = 1'b0;
        rstn = 1'b0;
        errors = 0;
        check_count = 0;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        chk("privileged", 32'h1, {31'h0, privileged});
        chk("handler", 32'h0, {31'h0, handler_mode});
        rd(`CRF_OFF_EXE, 1'b0);
        chk("exe reset", 32'h0100_0000, u_crf_pipe_model.rd_q);
        $display("Test reset done");

        foreach (ROWS[i])
        begin
            wr(ROWS[i].a, ROWS[i].d);
            rd(ROWS[i].a, 1'b0);
            chk("row word", ROWS[i].e, u_crf_pipe_model.rd_q);
            chk("row fault", 32'h0, {31'h0, u_crf_pipe_model.flt_q});
        end
        rd(`CRF_OFF_PSW, 1'b0);
        chk("combined", 32'hff00_fc00, u_crf_pipe_model.rd_q);
        $display("Test rows done");

        foreach (MROWS[i])
        begin
            wr(`CRF_OFF_PRIM, {31'h0, MROWS[i].p});
            wr(`CRF_OFF_FLTM, {31'h0, MROWS[i].f});
            wr(`CRF_OFF_BPRI, {23'h0, MROWS[i].b});
            u_crf_pipe_model.ask(MROWS[i].r);
            chk("req_ok", {31'h0, MROWS[i].ok}, {31'h0, req_ok});
        end
        $display("Test masks done");

        u_crf_pipe_model.pulse(0, 32'h0000_4443);
        rd(`CRF_OFF_LR, 1'b0);
        chk("return addr", 32'h0000_4443, u_crf_pipe_model.rd_q);
        u_crf_pipe_model.pulse(1, 32'h0000_3003);
        chk("ip", 32'h0000_3002, instruction_pointer);
        u_crf_pipe_model.pulse(2, 32'h0000_0015);
        rd(`CRF_OFF_APP, 1'b0);
        chk("flags", 32'ha800_0000, u_crf_pipe_model.rd_q);
        $display("Test events done");

        wr(`CRF_OFF_MSP, 32'h0000_0100);
        wr(`CRF_OFF_PSP, 32'h0000_0203);
        rd(`CRF_OFF_PSP, 1'b0);
        chk("psp", 32'h0000_0200, u_crf_pipe_model.rd_q);
        chk("sp main", 32'h0000_0100, stack_ptr);
        wr(`CRF_OFF_CTRL, 32'h0000_0002);
        chk("sp alt", 32'h0000_0200, stack_ptr);
        wr(`CRF_OFF_CTRL, 32'h0000_0001);
        chk("user", 32'h0, {31'h0, privileged});
        chk("sp user", 32'h0000_0200, stack_ptr);
        rd(`CRF_OFF_PRIM, 1'b0);
        chk("user fault", 32'h1, {31'h0, u_crf_pipe_model.flt_q});
        chk("user data", 32'h0, u_crf_pipe_model.rd_q);
        wr(`CRF_OFF_CTRL, 32'h0000_0000);
        chk("ctrl fault", 32'h1, {31'h0, u_crf_pipe_model.flt_q});
        chk("still user", 32'h0, {31'h0, privileged});
        rd(8'h20, 1'b1);
        chk("narrow high", 32'h1, {31'h0, u_crf_pipe_model.flt_q});
        rd(8'h1c, 1'b1);
        chk("narrow low", 32'h0000_0007, u_crf_pipe_model.rd_q);
        $display("Test stack done");

        u_crf_pipe_model.pulse(3, 32'h0000_0005);
        chk("handler", 32'h1, {31'h0, handler_mode});
        chk("priv handler", 32'h1, {31'h0, privileged});
        chk("exc num", 32'h5, {23'h0, exc_active_num});
        chk("sp handler", 32'h0000_0100, stack_ptr);
        rd(`CRF_OFF_INT, 1'b0);
        chk("int status", 32'h0000_0005, u_crf_pipe_model.rd_q);
        wr(`CRF_OFF_CTRL, 32'h0000_0000);
        u_crf_pipe_model.pulse(4, 32'h0000_0000);
        chk("thread", 32'h0, {31'h0, handler_mode});
        chk("exc clear", 32'h0, {23'h0, exc_active_num});
        $display("Test exception done");

        wr(`CRF_OFF_EXE, 32'h0000_0000);
        chk("clear fault", 32'h1, {31'h0, u_crf_pipe_model.flt_q});
        rd(`CRF_OFF_EXE, 1'b0);
        chk("compact", 32'h0100_0000, u_crf_pipe_model.rd_q);
        wr(`CRF_OFF_PSW, 32'h5100_0400);
        chk("psw fault", 32'h0, {31'h0, u_crf_pipe_model.flt_q});
        rd(`CRF_OFF_PSW, 1'b0);
        chk("psw joint", 32'h5100_0400, u_crf_pipe_model.rd_q);
        $display("Test compact done");
        complete_run();
    end

endmodule : testbench
